/* hdl/sbsc_ctrl.sv */
`timescale 1ns/1ps
`include "sbsc_consts.svh"
// Notes on behaviour
// [RQ1] Load with write strobe high starts read
// [RQ2] Advance high continues read at next address
// [RQ3] Read with output drive off is dummy
// [RQ4] Load with strobe and lane low starts write
// [RQ5] Advance during write writes selected lanes
// [RQ6] Write start with no lanes aborts
// [RQ7] Continuation with no lanes only advances address
// [RQ8] Clock gate high ignores the edge
// [RQ9] Each low lane writes byte and parity
// [RQ10] Narrow build has only lanes A, B
// [RQ11] Write cycle always tristates data pins
// [RQ12] Output drive asynchronous, masked during writes
// [RQ13] Read drives data only when enabled
// [RQ14] Powers up deselected with pins tristated
// [RQ15] Inactive select on load deselects device
// [RQ16] Mode picks linear or interleaved order
// [RQ17] Strobe at burst start fixes access type
// [RQ18] Write data taken on next edge
// [RQ19] Sleep takes two cycles in and out
module sbsc_ctrl #(
	parameter int LANES = `SBSC_LANES_WIDE,
	parameter int ADDR_BITS = `SBSC_ADDR_BITS,
	parameter int LANE_BITS = `SBSC_LANE_BITS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_BITS-1:0] address,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic advance_not_load,
	input wire logic write_strobe_n,
	input wire logic [LANES-1:0] byte_lane_select_n,
	input wire logic clock_gate_n,
	input wire logic output_drive_n,
	input wire logic burst_mode,
	input wire logic sleep_request,
	input wire logic [LANES*LANE_BITS-1:0] data_in,
	input wire logic [LANES-1:0] parity_pins_in,
	output logic [LANES*LANE_BITS-1:0] data_out,
	output logic [LANES-1:0] parity_pins_out,
	output logic data_oe,
	output sbsc_pkg::sbsc_burst_e burst_state,
	output logic asleep
);
	import sbsc_pkg::*;

	localparam int DEPTH = 1 << ADDR_BITS;
	localparam int SLP = `SBSC_SLEEP_CYCLES;

	// Array storage sits in each lane's generate scope
	logic [ADDR_BITS-1:0] rd_addr;
	logic rd_take;

	sbsc_burst_e burst_q;
	sbsc_sleep_e sleep_q;
	logic [ADDR_BITS-1:0] base_q;
	logic [1:0] step_q;
	logic [1:0] step_d;
	logic [ADDR_BITS-1:0] nxt_addr;
	logic [`SBSC_SYNC_STAGES-1:0] zz_sync_q;
	logic zz_q;
	logic [1:0] slp_cnt_q;
	logic wr_pend_q;
	logic [LANES-1:0] wr_lanes_q;
	logic [ADDR_BITS-1:0] wr_addr_q;
	logic rd_valid_q;
	logic [LANES*LANE_BITS-1:0] rd_data_q;
	logic [LANES-1:0] rd_par_q;
	logic selected;
	logic live;
	logic load_rd;
	logic load_wr;
	logic cont;

	// Burst order over the two low address bits
	function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] step,
		input logic mode);
		burst_low = mode ? (start ^ step) : 2'(start + step); // RQ16
	endfunction : burst_low

	assign nxt_addr = {base_q[ADDR_BITS-1:2], burst_low(base_q[1:0], step_d, burst_mode)};
	assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	// Edges count only while awake and not gated
	assign live = (sleep_q == SBSC_AWAKE) && !clock_gate_n; // RQ8
	assign load_rd = live && !advance_not_load && selected && write_strobe_n; // RQ1
	assign load_wr = live && !advance_not_load && selected && !write_strobe_n; // RQ4
	assign cont = live && advance_not_load && (burst_q != SBSC_IDLE); // RQ2 RQ17
	assign step_d = 2'(step_q + 2'h1);
	// Read address is the one the taken edge points at, so data lines up with valid
	assign rd_take = load_rd || (cont && burst_q == SBSC_READ); // RQ1 RQ2
	assign rd_addr = load_rd ? address : nxt_addr;

	// Pin synchroniser: change accepted when last two stages agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			zz_sync_q <= '0;
			zz_q <= 1'b0;
		end else begin
			zz_sync_q <= {zz_sync_q[`SBSC_SYNC_STAGES-2:0], sleep_request};
			if (zz_sync_q[`SBSC_SYNC_STAGES-1] == zz_sync_q[`SBSC_SYNC_STAGES-2]) begin
				zz_q <= zz_sync_q[`SBSC_SYNC_STAGES-1];
			end
		end
	end

	// Sleep entry and exit each take SLP cycles
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sleep_q <= SBSC_AWAKE;
			slp_cnt_q <= 2'h0;
		end else begin
			unique case (sleep_q)
				SBSC_AWAKE: begin
					if (zz_q) begin
						sleep_q <= SBSC_ENTERING;
						slp_cnt_q <= 2'h1;
					end
				end
				SBSC_ENTERING: begin
					if (slp_cnt_q == 2'(SLP)) begin // RQ19
						sleep_q <= SBSC_ASLEEP;
					end else begin
						slp_cnt_q <= 2'(slp_cnt_q + 2'h1);
					end
				end
				SBSC_ASLEEP: begin
					if (!zz_q) begin
						sleep_q <= SBSC_LEAVING;
						slp_cnt_q <= 2'h1;
					end
				end
				SBSC_LEAVING: begin
					if (slp_cnt_q == 2'(SLP)) begin // RQ19
						sleep_q <= SBSC_AWAKE;
					end else begin
						slp_cnt_q <= 2'(slp_cnt_q + 2'h1);
					end
				end
			endcase
		end
	end

	// Burst control; reset stands in for power-up
	always_ff @(posedge clk) begin
		if (!rstn) begin
			burst_q <= SBSC_IDLE; // RQ14
			base_q <= '0;
			step_q <= 2'h0;
		end else if (sleep_q != SBSC_AWAKE) begin
			// Pending accesses are dropped on sleep entry
			burst_q <= SBSC_IDLE; // RQ19
		end else if (load_rd) begin
			burst_q <= SBSC_READ;
			base_q <= address;
			step_q <= 2'h0;
		end else if (load_wr) begin
			burst_q <= SBSC_WRITE;
			base_q <= address;
			step_q <= 2'h0;
		end else if (live && !advance_not_load) begin
			burst_q <= SBSC_IDLE; // RQ15
		end else if (cont) begin
			step_q <= step_d; // RQ2 RQ7
		end
	end

	// Write address phase; data follows on the next live edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			wr_lanes_q <= '0;
			wr_addr_q <= '0;
		end else if (sleep_q != SBSC_AWAKE) begin
			wr_pend_q <= 1'b0;
		end else if (live) begin
			// All lanes high aborts: address still loads, nothing written
			wr_pend_q <= (load_wr || (cont && burst_q == SBSC_WRITE))
				&& !(&byte_lane_select_n); // RQ5 RQ6 RQ7
			wr_lanes_q <= ~byte_lane_select_n; // RQ10
			wr_addr_q <= load_wr ? address : nxt_addr;
		end
	end

	// Per-lane array writes, byte with its parity bit
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [LANE_BITS-1:0] lane_mem [DEPTH];
		logic lane_par [DEPTH];
		logic [LANE_BITS-1:0] rd_byte_q;
		logic rd_bit_q;
		always_ff @(posedge clk) begin
			if (rstn && live && wr_pend_q && wr_lanes_q[g]) begin // RQ18
				lane_mem[wr_addr_q] <= data_in[g*LANE_BITS +: LANE_BITS]; // RQ9
				lane_par[wr_addr_q] <= parity_pins_in[g]; // RQ9
			end
		end
		// Only taken read edges reload the output flops; stalls hold them
		always_ff @(posedge clk) begin
			if (!rstn) begin
				rd_byte_q <= '0;
				rd_bit_q <= 1'b0;
			end else if (rd_take) begin
				rd_byte_q <= lane_mem[rd_addr];
				rd_bit_q <= lane_par[rd_addr];
			end
		end
		assign rd_data_q[g*LANE_BITS +: LANE_BITS] = rd_byte_q;
		assign rd_par_q[g] = rd_bit_q;
	end

	// Read data valid for the cycle after a read address edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_valid_q <= 1'b0;
		end else if (sleep_q != SBSC_AWAKE) begin
			rd_valid_q <= 1'b0;
		end else if (live) begin
			rd_valid_q <= rd_take; // RQ1 RQ2
		end
	end

	// Read data and its valid both load on the taken edge
	assign data_out = rd_data_q;
	assign parity_pins_out = rd_par_q;
	// Output drive is not clocked; write cycles mask it
	assign data_oe = rd_valid_q && !wr_pend_q && !output_drive_n; // RQ3 RQ11 RQ12 RQ13
	assign burst_state = burst_q;
	assign asleep = (sleep_q != SBSC_AWAKE);
endmodule : sbsc_ctrl

/* hdl/sbsc_consts.svh */
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH
// Data width per byte lane and lane count of the wide build
`define SBSC_LANE_BITS 8
`define SBSC_LANES_WIDE 4
`define SBSC_ADDR_BITS 18
// Sleep entry and exit, in clock cycles
`define SBSC_SLEEP_CYCLES 2
// Depth of the pin synchroniser for the asynchronous sleep input
`define SBSC_SYNC_STAGES 3
`endif

/* hdl/sbsc_pkg.sv */
package sbsc_pkg;
	typedef enum logic [1:0] {
		SBSC_IDLE,
		SBSC_READ,
		SBSC_WRITE
	} sbsc_burst_e;
	typedef enum logic [1:0] {
		SBSC_AWAKE,
		SBSC_ENTERING,
		SBSC_ASLEEP,
		SBSC_LEAVING
	} sbsc_sleep_e;
endpackage : sbsc_pkg

/* tb/sbsc_checker.sv */
`timescale 1ns/1ps
module sbsc_checker #(
	parameter int LANES = 4,
	parameter int LANE_BITS = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic chip_select_first_n,
	input wire logic chip_select_second,
	input wire logic chip_select_third_n,
	input wire logic advance_not_load,
	input wire logic write_strobe_n,
	input wire logic [LANES-1:0] byte_lane_select_n,
	input wire logic clock_gate_n,
	input wire logic output_drive_n,
	input wire logic data_oe,
	input wire logic [1:0] burst_state,
	input wire logic asleep
);
	import sbsc_pkg::*;
	logic live, ld, sel;
	assign live = !clock_gate_n && !asleep;
	assign ld = live && !advance_not_load;
	assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_RD_START: assert property (ld && sel && write_strobe_n |=> burst_state == SBSC_READ)
		else $error("no read burst");
	AST_WR_START: assert property (ld && sel && !write_strobe_n && !(&byte_lane_select_n)
		|=> burst_state == SBSC_WRITE) else $error("no write burst");
	AST_DESEL: assert property (ld && !sel |=> burst_state == SBSC_IDLE)
		else $error("no deselect");
	AST_STALL: assert property (clock_gate_n && !asleep |=> $stable(burst_state))
		else $error("stall moved state");
	AST_KEEP: assert property (live && advance_not_load |=> burst_state == $past(burst_state))
		else $error("burst type changed");
	AST_WR_TRI: assert property (burst_state == SBSC_WRITE |-> !data_oe)
		else $error("driven in write");
	AST_RD_OE: assert property (burst_state == SBSC_READ |-> data_oe == !output_drive_n)
		else $error("read drive wrong");
	AST_IDLE_TRI: assert property (burst_state == SBSC_IDLE || asleep |-> !data_oe)
		else $error("driven while idle");
endmodule : sbsc_checker
bind sbsc_ctrl sbsc_checker #(.LANES(LANES), .LANE_BITS(LANE_BITS)) u_chk (.clk(clk),
	.rstn(rstn), .chip_select_first_n(chip_select_first_n),
	.chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
	.advance_not_load(advance_not_load), .write_strobe_n(write_strobe_n),
	.byte_lane_select_n(byte_lane_select_n), .clock_gate_n(clock_gate_n),
	.output_drive_n(output_drive_n), .data_oe(data_oe), .burst_state(burst_state),
	.asleep(asleep));

/* tb/sbsc_host.sv */
`timescale 1ns/1ps
module sbsc_host (
	input wire logic clk,
	input wire logic drive,
	input wire logic [35:0] value,
	output logic [31:0] data_in,
	output logic [3:0] parity_in
);
	logic [35:0] last_q;
	always_ff @(posedge clk) if (drive) last_q <= value;
	// Released pins invert, so stale data never looks valid
	assign {parity_in, data_in} = drive ? value : ~last_q;
endmodule : sbsc_host

/* tb/sync_burst_sram_bus_control_test.sv */
`timescale 1ns/1ps
module sync_burst_sram_bus_control_test;
	import sbsc_pkg::*;
	logic clk, rstn, cs1n, adv, wen, cgn, odn, mode, slp, drv, oe, aslp, rdv, n_odn, n_md, n_slp;
	logic p_cg, p_adv, p_we, p_cs, cs2, cs3n;
	logic [3:0] bl, pin, pout, p_bl;
	logic [1:0] p_a;
	logic [17:0] addr;
	logic [31:0] din, dout;
	logic [35:0] hv, p_wd, rexp;
	logic [35:0] em [4];
	sbsc_burst_e bst;
	int error_cnt = 0, n_compared = 0, bs = 0;
	sbsc_ctrl DUT (.clk(clk), .rstn(rstn), .address(addr), .chip_select_first_n(cs1n),
		.chip_select_second(cs2), .chip_select_third_n(cs3n), .advance_not_load(adv),
		.write_strobe_n(wen), .byte_lane_select_n(bl), .clock_gate_n(cgn),
		.output_drive_n(odn), .burst_mode(mode), .sleep_request(slp), .data_in(din),
		.parity_pins_in(pin), .data_out(dout), .parity_pins_out(pout), .data_oe(oe),
		.burst_state(bst), .asleep(aslp));
	sbsc_host host (.clk(clk), .drive(drv), .value(hv), .data_in(din), .parity_in(pin));
	task chk(input string nm, input logic [35:0] e, g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task print_verdict;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task op(input logic cg, a_l, we, cs, input logic [3:0] ln, input logic [1:0] a,
		input logic [35:0] wd);
		@(posedge clk);
		if (!p_cg) begin
			if (!p_adv) bs = p_cs ? (p_we ? 1 : 2) : 0;
			rdv = bs == 1;
			rexp = em[p_a];
			if (bs == 2 && p_bl != 4'hf)
				for (int g = 0; g < 36; g++)
					if (!p_bl[g < 32 ? g / 8 : g - 32]) em[p_a][g] = p_wd[g];
		end
		// Write data follows a live write edge by one edge
		drv <= !p_cg && bs == 2 && p_bl != 4'hf;
		hv <= p_wd;
		cgn <= cg;
		adv <= a_l;
		wen <= we;
		{cs1n, cs2, cs3n} <= cs ? 3'b010 : {a != 2'h1 && a != 2'h2, a != 2'h1, a == 2'h2};
		bl <= ln;
		odn <= n_odn;
		mode <= n_md;
		slp <= n_slp;
		addr <= {16'h0004, a} ^ {18{a_l}};
		{p_cg, p_adv, p_we, p_cs, p_bl, p_a, p_wd} = {cg, a_l, we, cs, ln, a, wd};
		@(negedge clk);
		chk("data_oe", 36'(rdv && !odn), 36'(oe));
		if (rdv && !odn) chk("read data", rexp, {pout, dout});
	endtask : op
	task burst(input logic we, md, o, input logic [1:0] a0, input logic [15:0] ln, input int st);
		logic [1:0] a;
		n_md = md;
		n_odn = o;
		for (int i = 0; i < 4; i++) begin
			a = md ? a0 ^ 2'(i) : a0 + 2'(i);
			if (i == st) op(1, 1, we, 1, ln[4*i+:4], a, 36'h0);
			op(0, i != 0, we, 1, ln[4*i+:4], a, 36'h9a5c3e10f ^ {9{2'(i), a0}});
		end
		op(0, 0, 1, 0, 4'hf, a0, 36'h0);
	endtask : burst
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		{rstn, adv, cgn, mode, slp, drv, n_md, n_slp, cs3n, rdv} = 0;
		{cs1n, cs2, wen, odn, n_odn, p_cg} = 6'h3f;
		{bl, addr, hv} = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("state", 36'(SBSC_IDLE), 36'(bst));
		burst(0, 0, 1, 2'h2, 16'h0000, 9);
		burst(0, 1, 0, 2'h1, 16'h58fe, 9);
		op(0, 0, 0, 1, 4'hf, 2'h0, 36'h0);
		burst(1, 0, 0, 2'h3, 16'h0000, 2);
		burst(1, 1, 1, 2'h1, 16'h0000, 9);
		burst(1, 1, 0, 2'h2, 16'h0000, 9);
		n_slp = 1;
		repeat (8) op(0, 0, 1, 0, 4'hf, 2'h0, 36'h0);
		chk("asleep", 36'h1, 36'(aslp));
		n_slp = 0;
		repeat (8) op(0, 0, 1, 0, 4'hf, 2'h0, 36'h0);
		chk("awake", 36'h0, 36'(aslp));
		print_verdict();
	end
endmodule : sync_burst_sram_bus_control_test
